// *** sim/test_dual_pwm_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_dual_pwm_timer
   import dpwm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, pulse1_output, pulse2_output, irq;
   wire logic [1:0] pv;
   logic [31:0] seed, v, pnote;
   logic [33:0] bnote;
   logic [33:0] bq[$];
   logic [31:0] pq[2][$];
   logic [1:0] seen, pprev;
   int err_count, comparisons, a, c, k, n, q, e, qmax;
   int per[2], hi[2], rises[2], p[2], d[2];
   int rt[4] = '{2, 8, 32, 64};

   dpwm_dual_timer #(.TW(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse1_output(pulse1_output), .pulse2_output(pulse2_output), .irq(irq));

   assign pv = {pulse2_output, pulse1_output};

   // 10 MHz clock
   always #50 pclk = ~pclk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check_reg(input string nm, input logic [32:0] ex, input logic [32:0] got);
      comparisons++;
      if (got !== ex) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic check_flag(input string nm, input logic ex, input logic got);
      comparisons++;
      if (got !== ex) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", nm, ex, got);
      end
   endtask

   task automatic check_pwm(input int ch, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex) begin
         err_count++;
         $display("MISMATCH pwm%0d_high_period expected %h seen %h", ch + 1, ex, got);
      end
   endtask

   task tally_and_finish();
      $display("Errors %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One APB transfer; an idle cycle after release keeps psel from being driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [31:0] ex,
                      input logic exerr);
      int w;
      w = 0;
      bq.push_back({~wr, exerr, ex});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 20);
      if (w >= 20) begin
         err_count++;
         $display("MISMATCH pready expected 1 seen timeout");
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
      apb(1'b0, ad, 32'h0, ex, 1'b0);
   endtask

   // Bus answers are matched against the oldest note; write data is not compared
   always @(posedge pclk) begin
      if (presetn === 1'b1 && psel && penable && pready === 1'b1) begin
         if (bq.size() == 0) begin
            err_count++;
            $display("MISMATCH apb_note expected queued seen none");
         end else begin
            bnote = bq.pop_front();
            check_reg($sformatf("apb_%h", paddr), bnote[32:0], {pslverr, bnote[33] ? prdata : bnote[31:0]});
         end
      end
   end

   // Rise-to-rise measurement; a period only counts once a previous rise was seen
   always @(posedge pclk) begin
      for (int ch = 0; ch < 2; ch++) begin
         if (pv[ch] === 1'b1 && pprev[ch] === 1'b0) begin
            rises[ch]++;
            if (seen[ch] && pq[ch].size() > 0) begin
               pnote = pq[ch].pop_front();
               check_pwm(ch, pnote, {hi[ch][15:0], per[ch][15:0]});
            end
            per[ch] = 1;
            hi[ch] = 1;
            seen[ch] = 1'b1;
         end else begin
            per[ch]++;
            if (pv[ch] === 1'b1) hi[ch]++;
         end
         pprev[ch] = pv[ch];
      end
   end

   initial begin
      repeat (60000) @(posedge pclk);
      err_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      tally_and_finish();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      seed = 32'h7FCC;
      seen = 2'b00;
      pprev = 2'b00;
      rises = '{0, 0};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset image of every mapped word
      for (a = 0; a <= 8'h40; a += 4) rd(8'(a), (a == 8'h08 || a == 8'h14) ? 32'h60 : 32'h0);
      apb(1'b0, 8'h44, 32'h0, 32'h0, 1'b1);
      apb(1'b1, DPWM_LATCH1_LO_OFF, 32'hFF, 32'h0, 1'b1);
      rd(DPWM_LATCH1_LO_OFF, 32'h0);
      // Random readback, only the low byte is kept
      for (a = 4; a <= 8'h18; a += 4) begin
         v = xs();
         wr(8'(a), v);
         rd(8'(a), {24'h0, v[7:0]});
      end
      wr(DPWM_INT_MASK_OFF, 32'hFFFFFFFC);
      rd(DPWM_INT_MASK_OFF, 32'h0);
      // Every prescale code on both channels, random period and duty
      for (k = 0; k < 4; k++) begin
         // Stop and rewind first: a timer already past a smaller period runs on to wrap
         wr(DPWM_CTRL_OFF, 32'h0);
         wr(DPWM_TIMER1_LO_OFF, 32'h0);
         wr(DPWM_TIMER1_HI_OFF, 32'h0);
         wr(DPWM_TIMER2_LO_OFF, 32'h0);
         wr(DPWM_TIMER2_HI_OFF, 32'h0);
         for (c = 0; c < 2; c++) begin
            p[c] = int'(xs() % 4);
            d[c] = 1 + int'(xs() % 32'((p[c] + 1) * 4 - 1));
            wr(c ? DPWM_PERIOD2_OFF : DPWM_PERIOD1_OFF, 32'(p[c]));
            wr(c ? DPWM_DUTY2_LO_OFF : DPWM_DUTY1_LO_OFF, 32'(d[c]));
            wr(c ? DPWM_DUTY2_HI_OFF : DPWM_DUTY1_HI_OFF, 32'h0);
         end
         wr(DPWM_CTRL_OFF, {24'h0, 4'hF, 2'(3 - k), 2'(k)});
         qmax = 0;
         for (c = 0; c < 2; c++) begin
            q = (p[c] + 1) * 4 * rt[c ? 3 - k : k];
            if (q > qmax) qmax = q;
         end
         repeat (2 * qmax + 4) @(posedge pclk);
         for (c = 0; c < 2; c++) begin
            q = (p[c] + 1) * 4 * rt[c ? 3 - k : k];
            e = d[c] * rt[c ? 3 - k : k];
            repeat (2) pq[c].push_back({e[15:0], q[15:0]});
         end
         n = 0;
         while ((pq[0].size() > 0 || pq[1].size() > 0) && n < 5000) begin
            @(posedge pclk);
            n++;
         end
         check_flag("pwm_drained", 1'b1, n < 5000);
      end
      // Flags, masking and write-one-to-clear
      rd(DPWM_INT_STATUS_OFF, 32'h3);
      check_flag("irq_masked", 1'b0, irq);
      wr(DPWM_INT_MASK_OFF, 32'h1);
      repeat (3) @(posedge pclk);
      check_flag("irq_unmasked", 1'b1, irq);
      wr(DPWM_CTRL_OFF, 32'h0);
      wr(DPWM_INT_STATUS_OFF, 32'h1);
      rd(DPWM_INT_STATUS_OFF, 32'h2);
      repeat (3) @(posedge pclk);
      check_flag("irq_cleared", 1'b0, irq);
      wr(DPWM_INT_STATUS_OFF, 32'h2);
      repeat (1000) @(posedge pclk);
      rd(DPWM_INT_STATUS_OFF, 32'h0);
      // Latch holds the last duty; a stopped timer never clears, so new duty waits
      rd(DPWM_LATCH1_LO_OFF, 32'(d[0]));
      rd(DPWM_LATCH2_LO_OFF, 32'(d[1]));
      wr(DPWM_DUTY1_LO_OFF, 32'h0);
      rd(DPWM_LATCH1_LO_OFF, 32'(d[0]));
      // Zero duty: the pin must never rise although the timer wraps
      wr(DPWM_PERIOD1_OFF, 32'h0);
      wr(DPWM_TIMER1_LO_OFF, 32'h0);
      wr(DPWM_TIMER1_HI_OFF, 32'h0);
      // Run gated first so the zero duty is latched before the pin is enabled
      wr(DPWM_CTRL_OFF, 32'h10);
      repeat (20) @(posedge pclk);
      n = rises[0];
      wr(DPWM_CTRL_OFF, 32'h50);
      repeat (40) @(posedge pclk);
      check_flag("pulse1_no_rise", 1'b1, rises[0] == n);
      rd(DPWM_LATCH1_LO_OFF, 32'h0);
      rd(DPWM_INT_STATUS_OFF, 32'h1);
      // Timer alone, pin enable kept clear
      wr(DPWM_DUTY1_LO_OFF, 32'h5);
      wr(DPWM_CTRL_OFF, 32'h10);
      repeat (40) @(posedge pclk);
      check_flag("pulse1_disabled", 1'b0, pulse1_output);
      tally_and_finish();
   end
endmodule // test_dual_pwm_timer
`default_nettype wire

// *** src/dpwm_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpwm_channel
   import dpwm_pkg::*;
#(
   parameter int TW = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [1:0] ps_sel,
   input wire logic ps_clear,
   input wire logic [7:0] period_value,
   input wire logic [TW-1:0] duty_value,
   input wire logic tmr_load,
   input wire logic [TW-1:0] tmr_load_val,
   output logic [TW-1:0] channel_timer,
   output logic [TW-1:0] duty_latch,
   output logic pulse,
   output logic period_match
);
   logic [5:0] ps_reg;
   logic [1:0] q_reg;
   logic [TW-1:0] tmr_reg;
   logic [TW-1:0] latch_reg;
   logic out_reg;

   // Prescaler terminal count per select code
   wire [5:0] ps_last = (ps_sel == DPWM_PS_DIV2) ? DPWM_LAST_DIV2 :
                        (ps_sel == DPWM_PS_DIV8) ? DPWM_LAST_DIV8 :
                        (ps_sel == DPWM_PS_DIV32) ? DPWM_LAST_DIV32 : DPWM_LAST_DIV64;
   wire step = enable && (ps_reg == ps_last);
   // Fine count in prescaled oscillator periods; timer is its upper part
   wire [TW+1:0] fine = {tmr_reg, q_reg};
   wire [TW+1:0] fine_next = fine + (TW+2)'(1);
   wire at_period = (tmr_reg == TW'(period_value)) && (q_reg == DPWM_LAST_QUARTER);
   wire match = step && at_period;
   wire duty_hit = step && !match && (fine_next == (TW+2)'(latch_reg));

   // Prescaler, cleared by control and own-timer writes so a new ratio starts clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_reg <= 6'h00;
      end else if (ps_clear || step) begin
         ps_reg <= 6'h00;
      end else if (enable) begin
         ps_reg <= ps_reg + 6'h01;
      end
   end

   // Timer: halts when disabled, wraps after period match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_reg <= '0;
         q_reg <= 2'h0;
      end else if (tmr_load) begin
         tmr_reg <= tmr_load_val;
         q_reg <= 2'h0;
      end else if (match) begin
         tmr_reg <= '0;
         q_reg <= 2'h0;
      end else if (step) begin
         {tmr_reg, q_reg} <= fine_next;
      end
   end

   // Duty latch and output level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= '0;
         out_reg <= 1'b0;
      end else if (match) begin
         latch_reg <= duty_value;
         out_reg <= (duty_value != '0);
      end else if (duty_hit) begin
         out_reg <= 1'b0;
      end
   end

   assign channel_timer = tmr_reg;
   assign duty_latch = latch_reg;
   assign pulse = out_reg;
   assign period_match = match;

   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_timer_wrap_zero: assert property (match && !tmr_load |=> tmr_reg == '0 && q_reg == 2'h0)
      else $error("timer not cleared after period match");
   a_out_set_match: assert property (match && duty_value != '0 |=> out_reg)
      else $error("output not set at period match");
   a_zero_duty_low: assert property (match && duty_value == '0 |=> !out_reg)
      else $error("output set with zero duty");
   a_latch_copy_duty: assert property (match |=> latch_reg == $past(duty_value))
      else $error("duty latch not loaded at match");
   a_latch_holds_between: assert property (!match |=> $stable(latch_reg))
      else $error("duty latch changed away from match");
   a_duty_clears_out: assert property (duty_hit |=> !out_reg)
      else $error("output not cleared at duty match");
   a_prescale_cleared: assert property (ps_clear |=> ps_reg == 6'h00)
      else $error("prescaler not cleared");
   a_timer_stops_off: assert property (!enable && !tmr_load |=> $stable(tmr_reg) && $stable(q_reg))
      else $error("disabled timer moved");
endmodule // dpwm_channel
`default_nettype wire

// *** src/dpwm_dual_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// - Timer equal to period clears to zero on next increment.
// - Period-match increment sets pulse output high unless duty is zero.
// - Period-match increment copies duty value into duty latch.
// - Period-match increment sets the channel's period-match flag.
// - PWM period is (period+1) times four times prescale oscillator cycles.
// - Duty latch equal to the fine count (timer and quarter bits) drives pulse output low.
// - Duty writes accepted anytime, latched only at next timer clear.
// - High time is duty times prescale oscillator cycles.
// - Each channel timer is a 10-bit up counter with own prescaler.
// - Prescale ratios 1:2, 1:8, 1:32, 1:64 via two bits per timer.
// - Prescaler clears on timer write, control write and reset.
// - Control bits 7..0: out2 en, out1 en, t2 en, t1 en, t2 ps, t1 ps.
// - Resets clear control, period, duty low and latch duty bits; duty high resets to 60h.
// - Clearing a timer enable stops that timer; bits 4 and 5.
module dpwm_dual_timer
   import dpwm_pkg::*;
#(
   parameter int TW = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pulse1_output,
   output logic pulse2_output,
   output logic irq
);
   // Software-visible registers
   logic [7:0] ctrl_reg;
   logic [7:0] duty1_lo_reg;
   logic [7:0] duty1_hi_reg;
   logic [7:0] period1_reg;
   logic [7:0] duty2_lo_reg;
   logic [7:0] duty2_hi_reg;
   logic [7:0] period2_reg;
   logic [1:0] int_status_reg;
   logic [1:0] int_mask_reg;
   // Bus answer and output flops
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic pulse1_reg;
   logic pulse2_reg;
   logic irq_reg;
   // Channel results
   logic [TW-1:0] timer1;
   logic [TW-1:0] timer2;
   logic [TW-1:0] latch1;
   logic [TW-1:0] latch2;
   logic out1;
   logic out2;
   logic match1;
   logic match2;

   // Bus phases; the slave answers in the first access cycle
   wire setup_ph = psel && !penable;
   wire access_ok = psel && penable && pready_reg;
   wire wr_en = access_ok && pwrite;
   wire [7:0] wbyte = pwdata[7:0];

   // Address decode
   wire hit_ctrl = (paddr == DPWM_CTRL_OFF);
   wire hit_d1l = (paddr == DPWM_DUTY1_LO_OFF);
   wire hit_d1h = (paddr == DPWM_DUTY1_HI_OFF);
   wire hit_p1 = (paddr == DPWM_PERIOD1_OFF);
   wire hit_d2l = (paddr == DPWM_DUTY2_LO_OFF);
   wire hit_d2h = (paddr == DPWM_DUTY2_HI_OFF);
   wire hit_p2 = (paddr == DPWM_PERIOD2_OFF);
   wire hit_l1l = (paddr == DPWM_LATCH1_LO_OFF);
   wire hit_l1h = (paddr == DPWM_LATCH1_HI_OFF);
   wire hit_l2l = (paddr == DPWM_LATCH2_LO_OFF);
   wire hit_l2h = (paddr == DPWM_LATCH2_HI_OFF);
   wire hit_t1l = (paddr == DPWM_TIMER1_LO_OFF);
   wire hit_t1h = (paddr == DPWM_TIMER1_HI_OFF);
   wire hit_t2l = (paddr == DPWM_TIMER2_LO_OFF);
   wire hit_t2h = (paddr == DPWM_TIMER2_HI_OFF);
   wire hit_ist = (paddr == DPWM_INT_STATUS_OFF);
   wire hit_imk = (paddr == DPWM_INT_MASK_OFF);
   wire hit_any = hit_ctrl | hit_d1l | hit_d1h | hit_p1 | hit_d2l | hit_d2h | hit_p2 |
                  hit_l1l | hit_l1h | hit_l2l | hit_l2h | hit_t1l | hit_t1h |
                  hit_t2l | hit_t2h | hit_ist | hit_imk;
   // Latch registers are not writable; writing them is an error
   wire hit_ro = hit_l1l | hit_l1h | hit_l2l | hit_l2h;
   wire bad_acc = !hit_any || (pwrite && hit_ro);

   // Write strobes, effective only on the accepted access edge
   wire wr_ctrl = wr_en && hit_ctrl;
   wire wr_t1l = wr_en && hit_t1l;
   wire wr_t1h = wr_en && hit_t1h;
   wire wr_t2l = wr_en && hit_t2l;
   wire wr_t2h = wr_en && hit_t2h;
   wire wr_ist = wr_en && hit_ist;

   // Control fields
   wire [1:0] t1_ps = ctrl_reg[DPWM_T1_PS_LSB +: 2];
   wire [1:0] t2_ps = ctrl_reg[DPWM_T2_PS_LSB +: 2];
   wire t1_en = ctrl_reg[DPWM_T1_EN_BIT];
   wire t2_en = ctrl_reg[DPWM_T2_EN_BIT];
   wire p1_oe = ctrl_reg[DPWM_P1_OE_BIT];
   wire p2_oe = ctrl_reg[DPWM_P2_OE_BIT];

   // Ten-bit duty values from high bits 1:0 and low byte
   wire [TW-1:0] duty1 = {duty1_hi_reg[1:0], duty1_lo_reg};
   wire [TW-1:0] duty2 = {duty2_hi_reg[1:0], duty2_lo_reg};

   // Timer load: each half write keeps the other half of the running count
   wire t1_load = wr_t1l || wr_t1h;
   wire t2_load = wr_t2l || wr_t2h;
   wire [TW-1:0] t1_val = wr_t1h ? {wbyte[1:0], timer1[7:0]} : {timer1[TW-1:8], wbyte};
   wire [TW-1:0] t2_val = wr_t2h ? {wbyte[1:0], timer2[7:0]} : {timer2[TW-1:8], wbyte};

   // Prescaler clear on control write or own timer write
   wire ps1_clr = wr_ctrl || t1_load;
   wire ps2_clr = wr_ctrl || t2_load;

   // Interrupt status: hardware set wins over a same-cycle write-one clear
   wire [1:0] ev = {match2, match1};
   wire [1:0] w1c = wr_ist ? wbyte[1:0] : 2'h0;
   wire [1:0] int_status_next = (int_status_reg & ~w1c) | ev;
   wire irq_next = |(int_status_next & int_mask_reg);

   // Read mux; timers read as zero since the count is not readable
   wire [7:0] rd_byte = hit_ctrl ? ctrl_reg :
                        hit_d1l ? duty1_lo_reg :
                        hit_d1h ? duty1_hi_reg :
                        hit_p1 ? period1_reg :
                        hit_d2l ? duty2_lo_reg :
                        hit_d2h ? duty2_hi_reg :
                        hit_p2 ? period2_reg :
                        hit_l1l ? latch1[7:0] :
                        hit_l1h ? {6'h00, latch1[TW-1:8]} :
                        hit_l2l ? latch2[7:0] :
                        hit_l2h ? {6'h00, latch2[TW-1:8]} :
                        hit_ist ? {6'h00, int_status_reg} :
                        hit_imk ? {6'h00, int_mask_reg} : 8'h00;

   // Answer flops: data and error prepared during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup_ph;
         pslverr_reg <= setup_ph && bad_acc;
         prdata_reg <= (setup_ph && !pwrite && !bad_acc) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= DPWM_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_reg <= wbyte;
      end
   end

   // Channel 1 duty and period; new duty waits in the latch stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty1_lo_reg <= DPWM_DUTY_LO_RST;
         duty1_hi_reg <= DPWM_DUTY_HI_RST;
         period1_reg <= DPWM_PERIOD_RST;
      end else if (wr_en) begin
         if (hit_d1l) duty1_lo_reg <= wbyte;
         if (hit_d1h) duty1_hi_reg <= wbyte;
         if (hit_p1) period1_reg <= wbyte;
      end
   end

   // Channel 2 duty and period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty2_lo_reg <= DPWM_DUTY_LO_RST;
         duty2_hi_reg <= DPWM_DUTY_HI_RST;
         period2_reg <= DPWM_PERIOD_RST;
      end else if (wr_en) begin
         if (hit_d2l) duty2_lo_reg <= wbyte;
         if (hit_d2h) duty2_hi_reg <= wbyte;
         if (hit_p2) period2_reg <= wbyte;
      end
   end

   // Interrupt status, mask and level output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= DPWM_INT_RST;
         int_mask_reg <= DPWM_INT_RST;
         irq_reg <= 1'b0;
      end else begin
         int_status_reg <= int_status_next;
         if (wr_en && hit_imk) int_mask_reg <= wbyte[1:0];
         irq_reg <= irq_next;
      end
   end

   // Pins are gated by output enables; a timer-only channel holds its pin low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse1_reg <= 1'b0;
         pulse2_reg <= 1'b0;
      end else begin
         pulse1_reg <= out1 && p1_oe;
         pulse2_reg <= out2 && p2_oe;
      end
   end

   // Two identical channels
   dpwm_channel #(.TW(TW)) u_ch1 (
      .pclk(pclk),
      .presetn(presetn),
      .enable(t1_en),
      .ps_sel(t1_ps),
      .ps_clear(ps1_clr),
      .period_value(period1_reg),
      .duty_value(duty1),
      .tmr_load(t1_load),
      .tmr_load_val(t1_val),
      .channel_timer(timer1),
      .duty_latch(latch1),
      .pulse(out1),
      .period_match(match1)
   );

   dpwm_channel #(.TW(TW)) u_ch2 (
      .pclk(pclk),
      .presetn(presetn),
      .enable(t2_en),
      .ps_sel(t2_ps),
      .ps_clear(ps2_clr),
      .period_value(period2_reg),
      .duty_value(duty2),
      .tmr_load(t2_load),
      .tmr_load_val(t2_val),
      .channel_timer(timer2),
      .duty_latch(latch2),
      .pulse(out2),
      .period_match(match2)
   );

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pulse1_output = pulse1_reg;
   assign pulse2_output = pulse2_reg;
   assign irq = irq_reg;

   // Checks on the register side
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flag1_on_match: assert property (match1 |=> int_status_reg[0])
      else $error("channel 1 match flag not set");
   a_flag2_on_match: assert property (match2 |=> int_status_reg[1])
      else $error("channel 2 match flag not set");
   a_ctrl_write_takes: assert property (wr_ctrl |=> ctrl_reg == $past(wbyte))
      else $error("control write lost");
   a_pin_gated_off: assert property (!p1_oe |=> !pulse1_output)
      else $error("disabled pulse pin driven high");
   a_irq_follows_mask: assert property (##1 irq == |($past(int_status_next) & $past(int_mask_reg)))
      else $error("interrupt level wrong");
   a_answer_one_cycle: assert property (setup_ph |=> pready)
      else $error("slave did not answer in access cycle");

   // Answer shape: ready is a one-cycle pulse, error and data only travel with it
   a_ready_one_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_data_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   a_unmapped_refused: assert property (setup_ph && !hit_any |=> pslverr)
      else $error("unmapped access not refused");
   a_latch_write_refused: assert property (setup_ph && pwrite && hit_ro |=> pslverr)
      else $error("latch write not refused");

   // Register writes land on the accepted access edge
   a_duty1_write_lands: assert property (wr_en && hit_d1l |=> duty1_lo_reg == $past(wbyte))
      else $error("duty 1 write lost");
   a_duty2_write_lands: assert property (wr_en && hit_d2l |=> duty2_lo_reg == $past(wbyte))
      else $error("duty 2 write lost");
   a_period1_write_lands: assert property (wr_en && hit_p1 |=> period1_reg == $past(wbyte))
      else $error("period 1 write lost");
   a_mask_write_lands: assert property (wr_en && hit_imk |=> int_mask_reg == $past(wbyte[1:0]))
      else $error("mask write lost");

   // A duty write away from the clear must not reach the latch yet
   a_duty1_waits: assert property (wr_en && hit_d1l && !match1 |=> $stable(latch1))
      else $error("duty 1 latched early");
   a_duty2_waits: assert property (wr_en && hit_d2l && !match2 |=> $stable(latch2))
      else $error("duty 2 latched early");

   // Status flags: a clear takes, but never against a same-cycle match
   a_flag1_set_wins: assert property (match1 && wr_ist && wbyte[0] |=> int_status_reg[0])
      else $error("flag 1 lost to clear");
   a_flag2_set_wins: assert property (match2 && wr_ist && wbyte[1] |=> int_status_reg[1])
      else $error("flag 2 lost to clear");
   a_flag1_cleared: assert property (wr_ist && wbyte[0] && !match1 |=> !int_status_reg[0])
      else $error("flag 1 not cleared");
   a_flag2_cleared: assert property (wr_ist && wbyte[1] && !match2 |=> !int_status_reg[1])
      else $error("flag 2 not cleared");
   a_irq_level_high: assert property (|(int_status_reg & int_mask_reg) && !wr_ist |=> irq)
      else $error("interrupt low with unmasked flag");

   // Timer writes load only the addressed half
   a_timer1_low_load: assert property (wr_t1l |=> timer1[7:0] == $past(wbyte))
      else $error("timer 1 low write lost");
   a_timer1_high_load: assert property (wr_t1h |=> timer1[TW-1:8] == $past(wbyte[1:0]))
      else $error("timer 1 high write lost");
   a_timer2_low_load: assert property (wr_t2l |=> timer2[7:0] == $past(wbyte))
      else $error("timer 2 low write lost");
   a_timer2_high_load: assert property (wr_t2h |=> timer2[TW-1:8] == $past(wbyte[1:0]))
      else $error("timer 2 high write lost");

   // Pins follow their channel while enabled and stay low otherwise
   a_pin1_follows: assert property (p1_oe |=> pulse1_output == $past(out1))
      else $error("pin 1 off its channel");
   a_pin2_follows: assert property (p2_oe |=> pulse2_output == $past(out2))
      else $error("pin 2 off its channel");
   a_pin2_gated_off: assert property (!p2_oe |=> !pulse2_output)
      else $error("disabled pin 2 high");

   // A stopped timer raises no period match
   a_t1_stop_quiet: assert property (!t1_en |-> !match1)
      else $error("stopped timer 1 matched");
   a_t2_stop_quiet: assert property (!t2_en |-> !match2)
      else $error("stopped timer 2 matched");
endmodule // dpwm_dual_timer
`default_nettype wire

// *** src/dpwm_pkg.sv ***
package dpwm_pkg;
   // Register byte offsets, one 32-bit word each
   localparam logic [7:0] DPWM_CTRL_OFF = 8'h00;
   localparam logic [7:0] DPWM_DUTY1_LO_OFF = 8'h04;
   localparam logic [7:0] DPWM_DUTY1_HI_OFF = 8'h08;
   localparam logic [7:0] DPWM_PERIOD1_OFF = 8'h0C;
   localparam logic [7:0] DPWM_DUTY2_LO_OFF = 8'h10;
   localparam logic [7:0] DPWM_DUTY2_HI_OFF = 8'h14;
   localparam logic [7:0] DPWM_PERIOD2_OFF = 8'h18;
   localparam logic [7:0] DPWM_LATCH1_LO_OFF = 8'h1C;
   localparam logic [7:0] DPWM_LATCH1_HI_OFF = 8'h20;
   localparam logic [7:0] DPWM_LATCH2_LO_OFF = 8'h24;
   localparam logic [7:0] DPWM_LATCH2_HI_OFF = 8'h28;
   localparam logic [7:0] DPWM_TIMER1_LO_OFF = 8'h2C;
   localparam logic [7:0] DPWM_TIMER1_HI_OFF = 8'h30;
   localparam logic [7:0] DPWM_TIMER2_LO_OFF = 8'h34;
   localparam logic [7:0] DPWM_TIMER2_HI_OFF = 8'h38;
   localparam logic [7:0] DPWM_INT_STATUS_OFF = 8'h3C;
   localparam logic [7:0] DPWM_INT_MASK_OFF = 8'h40;
   // Control field positions
   localparam int DPWM_T1_PS_LSB = 0;
   localparam int DPWM_T2_PS_LSB = 2;
   localparam int DPWM_T1_EN_BIT = 4;
   localparam int DPWM_T2_EN_BIT = 5;
   localparam int DPWM_P1_OE_BIT = 6;
   localparam int DPWM_P2_OE_BIT = 7;
   // Reset values
   localparam logic [7:0] DPWM_CTRL_RST = 8'h00;
   localparam logic [7:0] DPWM_DUTY_LO_RST = 8'h00;
   localparam logic [7:0] DPWM_DUTY_HI_RST = 8'h60;
   localparam logic [7:0] DPWM_PERIOD_RST = 8'h00;
   localparam logic [1:0] DPWM_INT_RST = 2'h0;
   // Prescale select codes and their last count (ratio minus one)
   typedef enum logic [1:0] {
      DPWM_PS_DIV2 = 2'b00,
      DPWM_PS_DIV8 = 2'b01,
      DPWM_PS_DIV32 = 2'b10,
      DPWM_PS_DIV64 = 2'b11
   } dpwm_ps_t;
   localparam logic [5:0] DPWM_LAST_DIV2 = 6'h01;
   localparam logic [5:0] DPWM_LAST_DIV8 = 6'h07;
   localparam logic [5:0] DPWM_LAST_DIV32 = 6'h1F;
   localparam logic [5:0] DPWM_LAST_DIV64 = 6'h3F;
   // Prescaled oscillator periods per timer increment, as last quarter index
   localparam logic [1:0] DPWM_LAST_QUARTER = 2'h3;
endpackage
